/* core/dsis_defines.svh */
// constants of the dma event-sync and interrupt-select block
// assumes a 16-bit cpu data-memory bus and word addresses
// How it works
// RULE1 - every channel picks its own trigger source through its own 4-bit selector field.
// RULE2 - selector 0 runs the channel free, 1 to 6 pick port 0 rx/tx, port 2 rx/tx, port 1 rx/tx.
// RULE3 - selector 13 picks the timer, 14 external interrupt 3, other codes are reserved for software.
// RULE4 - each of the six channels has its own completion interrupt toward the cpu.
// RULE5 - channels 0 to 3 share four cpu interrupt inputs with the serial ports, chosen by a 2-bit field.
// RULE6 - after reset the field is 0 and bits 6, 7, 10, 11 carry port 2 rx/tx and port 1 rx/tx.
// RULE7 - with field 1, bits 6 and 7 keep port 2 rx/tx while bits 10 and 11 carry channels 2 and 3.
// RULE8 - with field 2, bits 6, 7, 10 and 11 carry channels 0 to 3 and the serial ports are cut off.
// RULE9 - software never writes field value 3, whose routing is undefined.
// RULE10 - the priority and enable register with the routing field sits at address 54h.
// RULE11 - the sub-bank pointer sits at 55h, the incrementing data port at 56h, the plain one at 57h.
// RULE12 - an access through the incrementing port bumps the pointer by one afterwards, the plain one not.
// RULE13 - a synced channel moves one element per selected event, a free channel whenever enabled.
`ifndef DSIS_DEFINES_SVH
`define DSIS_DEFINES_SVH

// register addresses
`define DSIS_ADDR_PRIO        16'h0054
`define DSIS_ADDR_PTR         16'h0055
`define DSIS_ADDR_DATA_INC    16'h0056
`define DSIS_ADDR_DATA_PLAIN  16'h0057

// priority and enable register layout
`define DSIS_PRIO_RESET       16'h0000
`define DSIS_PRIO_MASK        16'hBFFF
`define DSIS_EN_LSB           0
`define DSIS_EN_MSB           5
`define DSIS_ROUTE_LSB        6
`define DSIS_ROUTE_MSB        7
`define DSIS_PRI_LSB          8
`define DSIS_PRI_MSB          13
`define DSIS_FREE_BIT         15

// routing field codes
`define DSIS_ROUTE_PORTS      2'h0
`define DSIS_ROUTE_MIXED      2'h1
`define DSIS_ROUTE_DMA        2'h2

// selector codes
`define DSIS_SEL_NONE         4'h0
`define DSIS_SEL_TIMER        4'hD
`define DSIS_SEL_EXT3         4'hE
`define DSIS_SEL_P0RX         1
`define DSIS_SEL_P1TX         6

// sub-bank layout
`define DSIS_PTR_RESET        16'h0000
`define DSIS_SUB_DEPTH        40
`define DSIS_SUB_SYNC_BASE    16'h0003
`define DSIS_SUB_STRIDE       16'h0005
`define DSIS_SYNC_LSB         12
`define DSIS_SYNC_MSB         15

`define DSIS_NUM_CHAN         6
`define DSIS_NUM_SHARED       4

`endif

/* core/dsis_pkg.sv */
// types shared by the dma event-sync and interrupt-select block
// assumes nothing of its surroundings
package dsis_pkg;

   typedef logic [3:0]  dsis_sel_t;
   typedef logic [15:0] dsis_word_t;

   // cpu data-memory request, taken on one edge
   typedef struct packed {
      dsis_word_t addr;
      logic       we;
      logic       re;
      dsis_word_t wdata;
   } dsis_bus_req_s;

   // read answer, one-cycle valid
   typedef struct packed {
      logic       rvalid;
      dsis_word_t rdata;
   } dsis_bus_rsp_s;

endpackage

/* core/dsis_subbank_mem.sv */
// sub-bank register store of the dma controller
// assumes one access per cycle; read data registered
`timescale 1ns/1ps
`default_nettype none
module dsis_subbank_mem #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 40,
   parameter int AW    = 6
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             we_i,
   input  wire logic             re_i,
   input  wire logic [AW-1:0]    addr_i,
   input  wire logic [WIDTH-1:0] wdata_i,
   output logic      [WIDTH-1:0] rdata_o
);

   logic [WIDTH-1:0] mem_q [DEPTH];

   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem_q[addr_i] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= '0;
      end else if (re_i) begin
         rdata_o <= mem_q[addr_i];
      end
   end

endmodule
`default_nettype wire

/* core/dsis_top.sv */
// dma event synchronisation and cpu interrupt routing
// assumes serial-port and timer events are one-cycle pulses on this clock
// assumes the counting engine pulses done per element and per completion
`timescale 1ns/1ps
`default_nettype none
`include "dsis_defines.svh"
module dsis_top #(
   parameter int NCH   = `DSIS_NUM_CHAN,
   parameter int DEPTH = `DSIS_SUB_DEPTH,
   parameter int AW    = 6
) (
   input  wire logic                   REF_CLK_I,
   input  wire logic                   RESETN_I,
   input  wire dsis_pkg::dsis_bus_req_s DM_REQ_I,
   output dsis_pkg::dsis_bus_rsp_s     DM_RSP_O,
   input  wire logic [5:0]             SER_EVT_I,
   input  wire logic                   TIMER_EVT_I,
   input  wire logic                   EXT_INT3_N_I,
   input  wire logic [NCH-1:0]         XFER_DONE_I,
   output logic      [NCH-1:0]         XFER_REQ_O,
   input  wire logic [NCH-1:0]         CHAN_DONE_I,
   input  wire logic                   PORT2_RX_IRQ_I,
   input  wire logic                   PORT2_TX_IRQ_I,
   input  wire logic                   PORT1_RX_IRQ_I,
   input  wire logic                   PORT1_TX_IRQ_I,
   output logic      [3:0]             CPU_SHARED_IRQ_O,
   output logic      [NCH-1:0]         CHAN_IRQ_O,
   output logic      [5:0]             CHAN_PRIO_O,
   output logic                        FREE_RUN_O
);

   // ************************************************************
   // functions
   // ************************************************************

   // sub-address of a channel's sync and frame count word
   function automatic logic [15:0] sync_subaddr(input int ch);
      sync_subaddr = 16'(`DSIS_SUB_SYNC_BASE + ch * `DSIS_SUB_STRIDE);
   endfunction

   // event picked by a selector; reserved codes never fire
   function automatic logic pick_event(input dsis_pkg::dsis_sel_t sel,
                                       input logic [15:0] evt);
      pick_event = evt[sel];
   endfunction

   // ************************************************************
   // external interrupt 3 pin
   // ************************************************************

   logic ext_meta_ff;
   logic ext_s2_ff;
   logic ext_s3_ff;
   logic ext_lvl_ff;
   logic ext_fall_ff;
   wire  ext_agree = (ext_s2_ff == ext_s3_ff);

   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         ext_meta_ff <= 1'b1;
         ext_s2_ff   <= 1'b1;
         ext_s3_ff   <= 1'b1;
      end else begin
         ext_meta_ff <= EXT_INT3_N_I;
         ext_s2_ff   <= ext_meta_ff;
         ext_s3_ff   <= ext_s2_ff;
      end
   end

   // falling edge of the filtered level is the event
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         ext_lvl_ff  <= 1'b1;
         ext_fall_ff <= 1'b0;
      end else begin
         if (ext_agree) begin
            ext_lvl_ff <= ext_s3_ff;
         end
         ext_fall_ff <= ext_agree & ext_lvl_ff & ~ext_s3_ff;
      end
   end

   // ************************************************************
   // bus decode
   // ************************************************************

   wire hit_prio  = (DM_REQ_I.addr == `DSIS_ADDR_PRIO);       // RULE10
   wire hit_ptr   = (DM_REQ_I.addr == `DSIS_ADDR_PTR);        // RULE11
   wire hit_inc   = (DM_REQ_I.addr == `DSIS_ADDR_DATA_INC);   // RULE11
   wire hit_plain = (DM_REQ_I.addr == `DSIS_ADDR_DATA_PLAIN); // RULE11
   wire hit_data  = hit_inc | hit_plain;
   wire hit_any   = hit_prio | hit_ptr | hit_data;
   wire acc       = DM_REQ_I.we | DM_REQ_I.re;
   wire wr_prio   = DM_REQ_I.we & hit_prio;
   wire wr_ptr    = DM_REQ_I.we & hit_ptr;
   wire wr_data   = DM_REQ_I.we & hit_data;
   wire rd_data   = DM_REQ_I.re & hit_data;
   wire inc_acc   = acc & hit_inc;

   // ************************************************************
   // priority, enable and routing register
   // ************************************************************

   logic [15:0] prio_ff;
   wire  [15:0] nxt_prio = DM_REQ_I.wdata & `DSIS_PRIO_MASK;
   wire  [NCH-1:0] chan_en = prio_ff[`DSIS_EN_MSB:`DSIS_EN_LSB];
   wire  [1:0]  route = prio_ff[`DSIS_ROUTE_MSB:`DSIS_ROUTE_LSB];

   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         prio_ff <= `DSIS_PRIO_RESET; // RULE6
      end else if (wr_prio) begin
         prio_ff <= nxt_prio;
      end
   end

   assign CHAN_PRIO_O = prio_ff[`DSIS_PRI_MSB:`DSIS_PRI_LSB];
   assign FREE_RUN_O  = prio_ff[`DSIS_FREE_BIT];

   // ************************************************************
   // sub-bank pointer
   // ************************************************************

   logic [15:0] ptr_ff;
   wire  [15:0] ptr_inc = 16'(ptr_ff + 16'h0001);
   wire  [15:0] nxt_ptr = wr_ptr ? DM_REQ_I.wdata : (inc_acc ? ptr_inc : ptr_ff); // RULE12

   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         ptr_ff <= `DSIS_PTR_RESET;
      end else begin
         ptr_ff <= nxt_ptr;
      end
   end

   // ************************************************************
   // sub-bank store
   // ************************************************************

   wire          ptr_in_range = (ptr_ff < 16'(DEPTH));
   wire [AW-1:0] mem_addr     = ptr_ff[AW-1:0];
   wire          mem_we       = wr_data & ptr_in_range;
   wire          mem_re       = rd_data & ptr_in_range;
   logic [15:0]  mem_rdata;

   dsis_subbank_mem #(
      .WIDTH (16),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_mem (
      .clk_i   (REF_CLK_I),
      .rst_n_i (RESETN_I),
      .we_i    (mem_we),
      .re_i    (mem_re),
      .addr_i  (mem_addr),
      .wdata_i (DM_REQ_I.wdata),
      .rdata_o (mem_rdata)
   );

   // ************************************************************
   // per-channel sync selectors
   // ************************************************************

   dsis_pkg::dsis_sel_t sel_ff [NCH];
   logic [NCH-1:0]      sel_wr;

   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         sel_wr[c] = wr_data & (ptr_ff == sync_subaddr(c)); // RULE1
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         for (int c = 0; c < NCH; c++) begin
            sel_ff[c] <= `DSIS_SEL_NONE;
         end
      end else begin
         for (int c = 0; c < NCH; c++) begin
            if (sel_wr[c]) begin
               sel_ff[c] <= DM_REQ_I.wdata[`DSIS_SYNC_MSB:`DSIS_SYNC_LSB]; // RULE1
            end
         end
      end
   end

   // ************************************************************
   // event vector indexed by selector code
   // ************************************************************

   logic [15:0] evt_vec;

   always_comb begin
      evt_vec = 16'h0000;
      evt_vec[`DSIS_SEL_P1TX:`DSIS_SEL_P0RX] = SER_EVT_I; // RULE2
      evt_vec[`DSIS_SEL_TIMER] = TIMER_EVT_I;           // RULE3
      evt_vec[`DSIS_SEL_EXT3]  = ext_fall_ff;           // RULE3
   end

   // ************************************************************
   // transfer requests
   // ************************************************************

   logic [NCH-1:0] pend_ff;
   logic [NCH-1:0] nxt_pend;
   logic [NCH-1:0] evt_hit;
   logic [NCH-1:0] unsync;

   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         unsync[c]  = (sel_ff[c] == `DSIS_SEL_NONE);       // RULE2
         evt_hit[c] = pick_event(sel_ff[c], evt_vec);      // RULE1
         // a fresh event outranks the completion of the previous one
         if (!chan_en[c] || unsync[c]) begin
            nxt_pend[c] = 1'b0;
         end else if (evt_hit[c]) begin
            nxt_pend[c] = 1'b1;                            // RULE13
         end else if (XFER_DONE_I[c]) begin
            nxt_pend[c] = 1'b0;                            // RULE13
         end else begin
            nxt_pend[c] = pend_ff[c];
         end
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         pend_ff <= '0;
      end else begin
         pend_ff <= nxt_pend;
      end
   end

   assign XFER_REQ_O = chan_en & (unsync | pend_ff); // RULE13

   // ************************************************************
   // completion interrupts and routing
   // ************************************************************

   logic [NCH-1:0] chan_irq_ff;
   logic [3:0]     shared_ff;
   logic [3:0]     nxt_shared;
   wire  [3:0]     port_irq = {PORT1_TX_IRQ_I, PORT1_RX_IRQ_I, PORT2_TX_IRQ_I, PORT2_RX_IRQ_I};
   wire  [3:0]     dma_irq  = CHAN_DONE_I[3:0];

   always_comb begin
      if (route == `DSIS_ROUTE_PORTS) begin
         nxt_shared = port_irq;                        // RULE6
      end else if (route == `DSIS_ROUTE_MIXED) begin
         nxt_shared = {dma_irq[3:2], port_irq[1:0]};   // RULE7
      end else if (route == `DSIS_ROUTE_DMA) begin
         nxt_shared = dma_irq;                         // RULE8
      end else begin
         nxt_shared = 4'h0;                            // RULE9
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         chan_irq_ff <= '0;
         shared_ff   <= 4'h0;
      end else begin
         chan_irq_ff <= CHAN_DONE_I; // RULE4
         shared_ff   <= nxt_shared;  // RULE5
      end
   end

   assign CHAN_IRQ_O       = chan_irq_ff;
   assign CPU_SHARED_IRQ_O = shared_ff;

   // ************************************************************
   // read path, two cycles
   // ************************************************************

   logic        rd1_ff;
   logic        rd1_mem_ff;
   logic [15:0] rd1_local_ff;
   logic [15:0] nxt_local;
   dsis_pkg::dsis_bus_rsp_s rsp_ff;
   wire         rd_hit = DM_REQ_I.re & hit_any;

   always_comb begin
      if (hit_prio) begin
         nxt_local = prio_ff;
      end else if (hit_ptr) begin
         nxt_local = ptr_ff;
      end else begin
         nxt_local = 16'h0000;
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         rd1_ff       <= 1'b0;
         rd1_mem_ff   <= 1'b0;
         rd1_local_ff <= 16'h0000;
      end else begin
         rd1_ff       <= rd_hit;
         rd1_mem_ff   <= mem_re;
         rd1_local_ff <= nxt_local;
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         rsp_ff <= '0;
      end else begin
         rsp_ff.rvalid <= rd1_ff;
         rsp_ff.rdata  <= rd1_mem_ff ? mem_rdata : rd1_local_ff;
      end
   end

   assign DM_RSP_O = rsp_ff;

endmodule
`default_nettype wire

/* dv/dsis_monitor.sv */
// port checker for dsis_top
// assumes a bind onto dsis_top and a single clock domain
`timescale 1ns/1ps
`default_nettype none
module dsis_monitor #(
   parameter int NCH = 6
) (
   input wire logic                    REF_CLK_I,
   input wire logic                    RESETN_I,
   input wire dsis_pkg::dsis_bus_req_s DM_REQ_I,
   input wire dsis_pkg::dsis_bus_rsp_s DM_RSP_O,
   input wire logic [NCH-1:0]          XFER_DONE_I,
   input wire logic [NCH-1:0]          XFER_REQ_O,
   input wire logic [NCH-1:0]          CHAN_DONE_I,
   input wire logic                    PORT2_RX_IRQ_I,
   input wire logic                    PORT2_TX_IRQ_I,
   input wire logic                    PORT1_RX_IRQ_I,
   input wire logic                    PORT1_TX_IRQ_I,
   input wire logic [3:0]              CPU_SHARED_IRQ_O,
   input wire logic [NCH-1:0]          CHAN_IRQ_O,
   input wire logic [5:0]              CHAN_PRIO_O,
   input wire logic                    FREE_RUN_O
);
   // ****************
   // shadow of routing field
   // ****************
   logic [1:0]      rt_ff;
   wire logic       wr_prio = DM_REQ_I.we && DM_REQ_I.addr == 16'h0054;
   wire logic       hit = DM_REQ_I.addr[15:2] == 14'h0015;
   wire logic       rd_hit = DM_REQ_I.re && hit;
   wire logic [3:0] prt = {PORT1_TX_IRQ_I, PORT1_RX_IRQ_I, PORT2_TX_IRQ_I, PORT2_RX_IRQ_I};
   wire logic [3:0] mix = {CHAN_DONE_I[3:2], PORT2_TX_IRQ_I, PORT2_RX_IRQ_I};
   wire logic [3:0] dma4 = CHAN_DONE_I[3:0];
   wire logic [6:0] pf = {DM_REQ_I.wdata[15], DM_REQ_I.wdata[13:8]};

   always_ff @(posedge REF_CLK_I or negedge RESETN_I)
      if (!RESETN_I) rt_ff <= 2'h0;
      else if (wr_prio) rt_ff <= DM_REQ_I.wdata[7:6];

   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RESETN_I);

   AST_RD_LAT: assert property (rd_hit |-> ##2 DM_RSP_O.rvalid)
      else $error("register read not answered in two cycles");
   AST_RD_MISS: assert property (DM_REQ_I.re && !hit |-> ##2 !DM_RSP_O.rvalid)
      else $error("unmapped read answered");
   AST_RV_SRC: assert property (DM_RSP_O.rvalid |-> $past(rd_hit, 2))
      else $error("read answer without request");
   AST_ROUTE_P: assert property (rt_ff == 2'h0 |=> CPU_SHARED_IRQ_O == $past(prt))
      else $error("route 0 lines wrong");
   AST_ROUTE_M: assert property (rt_ff == 2'h1 |=> CPU_SHARED_IRQ_O == $past(mix))
      else $error("route 1 lines wrong");
   AST_ROUTE_D: assert property (rt_ff == 2'h2 |=> CPU_SHARED_IRQ_O == $past(dma4))
      else $error("route 2 lines wrong");
   AST_CHAN_IRQ: assert property (1'h1 |=> CHAN_IRQ_O == $past(CHAN_DONE_I))
      else $error("channel irq not following done");
   AST_PRIO_WR: assert property (wr_prio |=> {FREE_RUN_O, CHAN_PRIO_O} == $past(pf))
      else $error("priority field not written");
   AST_PRIO_HOLD: assert property (!wr_prio |=> $stable({FREE_RUN_O, CHAN_PRIO_O}))
      else $error("priority field changed without write");
   AST_REQ_HOLD: assert property (XFER_REQ_O[0] && !XFER_DONE_I[0] && !DM_REQ_I.we
      |=> XFER_REQ_O[0])
      else $error("request dropped before done");

   COV_ROUTE_DMA: cover property (rt_ff == 2'h2 && CPU_SHARED_IRQ_O != 4'h0);
   COV_SYNC_REQ: cover property ($rose(XFER_REQ_O[0]));
   COV_READ: cover property (DM_RSP_O.rvalid);
endmodule
`default_nettype wire

/* dv/dsis_evt_model.sv */
// event sources and transfer engine beside dsis_top
// assumes commands from the bench one cycle ahead of each event
`timescale 1ns/1ps
`default_nettype none
module dsis_evt_model (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic [7:0] fire_i,
   input  wire logic [2:0] dly_i,
   input  wire logic [5:0] req_i,
   output logic      [5:0] ser_evt_o,
   output logic            timer_evt_o,
   output logic            ext_n_o,
   output logic      [5:0] done_o
);
   // ****************
   // events and element completion
   // ****************
   logic [2:0] cnt_ff [6];
   logic [3:0] low_ff;

   // pin idles high, held low some cycles per command
   assign ext_n_o = low_ff == 4'h0;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {timer_evt_o, ser_evt_o} <= 7'h00;
         low_ff <= 4'h0;
         done_o <= 6'h00;
         for (int c = 0; c < 6; c++) cnt_ff[c] <= 3'h0;
      end else begin
         {timer_evt_o, ser_evt_o} <= fire_i[6:0];
         low_ff <= fire_i[7] ? 4'hA : low_ff - {3'h0, |low_ff};
         // one element moved after dly_i + 1 cycles of request
         for (int c = 0; c < 6; c++) begin
            done_o[c] <= req_i[c] && !done_o[c] && cnt_ff[c] == dly_i;
            cnt_ff[c] <= (req_i[c] && !done_o[c]) ? cnt_ff[c] + 3'h1 : 3'h0;
         end
      end
   end
endmodule
`default_nettype wire

/* dv/dma_sync_and_irq_select_tb.sv */
// self-checking bench for dsis_top
// assumes dsis_evt_model on the event side and dsis_monitor bound in
`timescale 1ns/1ps
`default_nettype none
module dma_sync_and_irq_select_tb;
   logic                    clk = 1'h0;
   logic                    rst_n = 1'h0;
   dsis_pkg::dsis_bus_req_s rq = '0;
   dsis_pkg::dsis_bus_rsp_s rs;
   logic [7:0]              fire = 8'h00;
   logic [2:0]              dly = 3'h5;
   logic [3:0]              prt = 4'h0;
   logic [3:0]              shr;
   logic [5:0]              cdn = 6'h00;
   logic [5:0]              ser, dn, req, cirq, prio;
   logic                    tmr, ext_n, free;
   int                      error_cnt = 0;
   int                      n_tests = 0;

   always #20 clk = ~clk;

   dsis_top dut (
      .REF_CLK_I(clk), .RESETN_I(rst_n), .DM_REQ_I(rq), .DM_RSP_O(rs),
      .SER_EVT_I(ser), .TIMER_EVT_I(tmr), .EXT_INT3_N_I(ext_n),
      .XFER_DONE_I(dn), .XFER_REQ_O(req), .CHAN_DONE_I(cdn),
      .PORT2_RX_IRQ_I(prt[0]), .PORT2_TX_IRQ_I(prt[1]),
      .PORT1_RX_IRQ_I(prt[2]), .PORT1_TX_IRQ_I(prt[3]), .CPU_SHARED_IRQ_O(shr),
      .CHAN_IRQ_O(cirq), .CHAN_PRIO_O(prio), .FREE_RUN_O(free)
   );
   dsis_evt_model pm (
      .clk_i(clk), .rst_n_i(rst_n), .fire_i(fire), .dly_i(dly), .req_i(req),
      .ser_evt_o(ser), .timer_evt_o(tmr), .ext_n_o(ext_n), .done_o(dn)
   );

   // ****************
   // shared tasks
   // ****************
   task automatic test_done();
      $display("tests %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      n_tests++;
      if (s !== e) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      rq = '{a, 1'h1, 1'h0, d};
      cyc(1);
      rq = '0;
      cyc(1);
   endtask

   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      rq = '{a, 1'h0, 1'h1, 16'h0000};
      cyc(1);
      rq = '0;
      // answer stands in the second cycle after the taking edge
      cyc(1);
      chk({15'h0000, rs.rvalid}, 16'h0001);
      d = rs.rdata;
   endtask

   task automatic fire_evt(input logic [7:0] m);
      fire = m;
      cyc(1);
      fire = 8'h00;
      cyc(1);
   endtask

   task automatic wait_req(input logic v, input int n);
      for (int i = 0; i < n && req[0] !== v; i++) cyc(1);
      if (req[0] !== v) begin
         error_cnt++;
         test_done();
      end
   endtask

   // ****************
   // scenarios
   // ****************
   task automatic s_regs();
      logic [15:0] d;
      rd(16'h0054, d);
      chk(d, 16'h0000);
      wr(16'h0054, 16'hC23F);
      rd(16'h0054, d);
      chk(d, 16'h823F);
      chk({9'h000, free, prio}, 16'h0042);
      chk({10'h000, req}, 16'h003F);
      rq = '{16'h0058, 1'h0, 1'h1, 16'h0000};
      cyc(1);
      rq = '0;
      cyc(1);
      chk({15'h0000, rs.rvalid}, 16'h0000);
      wr(16'h0055, 16'h0003);
      wr(16'h0057, 16'h1000);
      rd(16'h0055, d);
      chk(d, 16'h0003);
      wr(16'h0056, 16'h1000);
      rd(16'h0055, d);
      chk(d, 16'h0004);
      wr(16'h0055, 16'h0003);
      rd(16'h0057, d);
      chk(d, 16'h1000);
      rd(16'h0056, d);
      chk(d, 16'h1000);
      rd(16'h0055, d);
      chk(d, 16'h0004);
      wr(16'h0054, 16'h0000);
   endtask

   task automatic s_route();
      logic [3:0] ex;
      // code 11b is never written
      for (int r = 0; r < 3; r++) begin
         wr(16'h0054, {8'h00, r[1:0], 6'h00});
         for (int k = 0; k < 2; k++) begin
            prt = k ? 4'hA : 4'h5;
            cdn = k ? 6'h05 : 6'h3A;
            ex = r == 0 ? prt : (r == 1 ? {cdn[3:2], prt[1:0]} : cdn[3:0]);
            cyc(1);
            chk({12'h000, shr}, {12'h000, ex});
            chk({10'h000, cirq}, {10'h000, cdn});
         end
      end
      prt = 4'h0;
      cdn = 6'h00;
      wr(16'h0054, 16'h0000);
   endtask

   task automatic s_sync();
      logic [3:0] c;
      logic       syn;
      logic [7:0] m;
      wr(16'h0054, 16'h0001);
      for (int i = 15; i >= 0; i--) begin
         c = i[3:0];
         syn = c inside {[4'h1:4'h6], 4'hD, 4'hE};
         m = (c >= 4'h1 && c <= 4'h6) ? 8'h01 << (c - 4'h1) :
             c == 4'hD ? 8'h40 : (c == 4'hE ? 8'h80 : 8'h7F);
         wr(16'h0055, 16'h0003);
         wr(16'h0057, {c, 12'h000});
         if (c == 4'h0) begin
            chk({15'h0000, req[0]}, 16'h0001);
         end else begin
            chk({15'h0000, req[0]}, 16'h0000);
            fire_evt(m);
            // pin filter delays the external event
            if (c == 4'hE) wait_req(1'h1, 8);
            chk({15'h0000, req[0]}, {15'h0000, syn});
            wait_req(1'h0, 12);
         end
      end
      wr(16'h0055, 16'h0003);
      wr(16'h0057, 16'h1000);
      dly = 3'h0;
      fire_evt(8'h01);
      chk({15'h0000, req[0]}, 16'h0001);
      cyc(2);
      chk({15'h0000, req[0]}, 16'h0000);
      wr(16'h0054, 16'h0000);
      chk({10'h000, req}, 16'h0000);
   endtask

   initial begin
      cyc(3);
      rst_n = 1'h1;
      s_regs();
      s_route();
      s_sync();
      test_done();
   end
endmodule

bind dsis_top dsis_monitor #(.NCH(NCH)) mon (
   .REF_CLK_I(REF_CLK_I), .RESETN_I(RESETN_I), .DM_REQ_I(DM_REQ_I), .DM_RSP_O(DM_RSP_O),
   .XFER_DONE_I(XFER_DONE_I), .XFER_REQ_O(XFER_REQ_O), .CHAN_DONE_I(CHAN_DONE_I),
   .PORT2_RX_IRQ_I(PORT2_RX_IRQ_I), .PORT2_TX_IRQ_I(PORT2_TX_IRQ_I),
   .PORT1_RX_IRQ_I(PORT1_RX_IRQ_I), .PORT1_TX_IRQ_I(PORT1_TX_IRQ_I),
   .CPU_SHARED_IRQ_O(CPU_SHARED_IRQ_O), .CHAN_IRQ_O(CHAN_IRQ_O),
   .CHAN_PRIO_O(CHAN_PRIO_O), .FREE_RUN_O(FREE_RUN_O)
);
`default_nettype wire
